// >>> hw/dmarh_channel.sv
/*
  One channel of the external request handshake: request qualification,
  transfer sequencing, request clear and last transfer flag.
  Assumes the request input is already synchronised to i_clk and the
  transfer engine acknowledges each transfer with a one-cycle done pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module dmarh_channel
  import dmarh_pkg::*;
#(
  parameter int unsigned CNT_W = DMARH_CNT_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_enable,
  input  wire logic             i_ext_type,
  input  wire logic             i_burst,
  input  wire logic [CNT_W-1:0] i_xfer_count,
  input  wire logic             i_req_sync,
  input  wire logic             i_xfer_done,
  output logic                  o_xfer_start,
  output logic                  o_request_clear,
  output logic                  o_last_xfer_flag,
  output logic                  o_block_done
);
  dmarh_state_e     state;
  logic [CNT_W-1:0] remain;
  logic             req_ok;
  logic             is_last;
  logic             drop_seen;

  // Request input is ignored unless the channel uses the external type
  assign req_ok  = i_enable && i_ext_type && i_req_sync;
  assign is_last = (remain == CNT_W'(1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state  <= DMARH_IDLE;
      remain <= '0;
    end else begin
      case (state)
        DMARH_IDLE: begin
          if (req_ok && (remain != '0)) begin
            state <= DMARH_XFER;
          end else if (remain == '0 && i_enable) begin
            remain <= i_xfer_count;
          end
        end
        DMARH_XFER: begin
          if (i_xfer_done) begin
            remain <= remain - CNT_W'(1);
            if (!i_burst) begin
              // Every steal transfer, the last one too, waits for the withdraw;
              // a drop already seen during the transfer counts, else it is lost
              state <= (drop_seen || !i_req_sync) ? DMARH_IDLE : DMARH_WDROP;
            end else if (is_last) begin
              state <= DMARH_IDLE;
            end else begin
              state <= DMARH_XFER;
            end
          end
        end
        DMARH_WDROP: begin
          if (!i_req_sync) begin
            state <= DMARH_IDLE;
          end
        end
        default: state <= DMARH_IDLE;
      endcase
    end
  end

  // Remember a withdraw seen mid-transfer so a quick device is not missed
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      drop_seen <= 1'b0;
    end else if (state == DMARH_XFER && !i_req_sync) begin
      drop_seen <= 1'b1;
    end else if (state == DMARH_IDLE) begin
      drop_seen <= 1'b0;
    end
  end

  // Transfer start pulse: entry into a transfer, or the next burst beat
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_xfer_start <= 1'b0;
    end else begin
      o_xfer_start <= (state == DMARH_IDLE && req_ok && remain != '0) ||
                      (state == DMARH_XFER && i_xfer_done && i_burst && !is_last);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_request_clear  <= DMARH_RST_LEVEL;
      o_last_xfer_flag <= DMARH_RST_LEVEL;
    end else begin
      o_request_clear  <= 1'b0;
      o_last_xfer_flag <= 1'b0;
      if (state == DMARH_IDLE && req_ok && remain != '0) begin
        // Cycle steal clears every transfer; burst only on the last one
        o_request_clear  <= !i_burst || is_last;
        o_last_xfer_flag <= is_last;
      end else if (state == DMARH_XFER && i_xfer_done && i_burst &&
                   remain == CNT_W'(2)) begin
        o_request_clear  <= 1'b1;
        o_last_xfer_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_block_done <= 1'b0;
    end else begin
      o_block_done <= (state == DMARH_XFER) && i_xfer_done && is_last;
    end
  end
endmodule : dmarh_channel
`default_nettype wire

// >>> hw/dmarh_pkg.sv
/*
  Package for the DMA external request handshake block: channel count,
  synchroniser depth, count width, reset level and handshake state encoding.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dmarh_pkg;
  localparam int unsigned DMARH_NUM_CH    = 2;
  localparam int unsigned DMARH_SYNC_LEN  = 2;
  localparam int unsigned DMARH_CNT_W     = 16;
  localparam logic        DMARH_RST_LEVEL = 1'b0;

  typedef enum logic [1:0] {
    DMARH_IDLE  = 2'b00,
    DMARH_XFER  = 2'b01,
    DMARH_WDROP = 2'b11
  } dmarh_state_e;
endpackage : dmarh_pkg

// >>> hw/dmarh_top.sv
/*
  Two-channel pin-level request handshake of the DMA controller.
  Assumes request pins are asynchronous level inputs from external devices
  and a transfer engine that answers each start with a done pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module dmarh_top
  import dmarh_pkg::*;
#(
  parameter int unsigned CNT_W    = DMARH_CNT_W,
  parameter int unsigned SYNC_LEN = DMARH_SYNC_LEN
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ch0_xfer_request,
  input  wire logic             i_ch1_xfer_request,
  input  wire logic             i_ch0_enable,
  input  wire logic             i_ch1_enable,
  input  wire logic             i_ch0_ext_type,
  input  wire logic             i_ch1_ext_type,
  input  wire logic             i_ch0_burst,
  input  wire logic             i_ch1_burst,
  input  wire logic [CNT_W-1:0] i_ch0_xfer_count,
  input  wire logic [CNT_W-1:0] i_ch1_xfer_count,
  input  wire logic             i_ch0_xfer_done,
  input  wire logic             i_ch1_xfer_done,
  output logic                  o_ch0_xfer_start,
  output logic                  o_ch1_xfer_start,
  output logic                  o_ch0_request_clear,
  output logic                  o_ch1_request_clear,
  output logic                  o_ch0_last_xfer_flag,
  output logic                  o_ch1_last_xfer_flag,
  output logic                  o_ch0_block_done,
  output logic                  o_ch1_block_done
);
  logic [DMARH_NUM_CH-1:0] req_raw;
  logic [DMARH_NUM_CH-1:0] req_sync;
  logic [DMARH_NUM_CH-1:0] en;
  logic [DMARH_NUM_CH-1:0] ext;
  logic [DMARH_NUM_CH-1:0] burst;
  logic [DMARH_NUM_CH-1:0] done;
  logic [DMARH_NUM_CH-1:0] start;
  logic [DMARH_NUM_CH-1:0] clr;
  logic [DMARH_NUM_CH-1:0] last;
  logic [DMARH_NUM_CH-1:0] bdone;
  logic [CNT_W-1:0]        count [DMARH_NUM_CH];
  logic [SYNC_LEN-1:0]     sync_chain [DMARH_NUM_CH];

  assign req_raw  = {i_ch1_xfer_request, i_ch0_xfer_request};
  assign en       = {i_ch1_enable, i_ch0_enable};
  assign ext      = {i_ch1_ext_type, i_ch0_ext_type};
  assign burst    = {i_ch1_burst, i_ch0_burst};
  assign done     = {i_ch1_xfer_done, i_ch0_xfer_done};
  assign count[0] = i_ch0_xfer_count;
  assign count[1] = i_ch1_xfer_count;

  for (genvar c = 0; c < DMARH_NUM_CH; c++) begin : g_ch
    // Extra latency is traded for metastability margin on the pins
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        sync_chain[c] <= '0;
      end else begin
        sync_chain[c] <= {sync_chain[c][SYNC_LEN-2:0], req_raw[c]};
      end
    end
    assign req_sync[c] = sync_chain[c][SYNC_LEN-1];

    dmarh_channel #(
      .CNT_W (CNT_W)
    ) u_chan (
      .i_clk            (i_clk),
      .i_rst_n          (i_rst_n),
      .i_enable         (en[c]),
      .i_ext_type       (ext[c]),
      .i_burst          (burst[c]),
      .i_xfer_count     (count[c]),
      .i_req_sync       (req_sync[c]),
      .i_xfer_done      (done[c]),
      .o_xfer_start     (start[c]),
      .o_request_clear  (clr[c]),
      .o_last_xfer_flag (last[c]),
      .o_block_done     (bdone[c])
    );
  end

  // Channel outputs are already flops; these are pure renames
  assign o_ch0_xfer_start     = start[0];
  assign o_ch1_xfer_start     = start[1];
  assign o_ch0_request_clear  = clr[0];
  assign o_ch1_request_clear  = clr[1];
  assign o_ch0_last_xfer_flag = last[0];
  assign o_ch1_last_xfer_flag = last[1];
  assign o_ch0_block_done     = bdone[0];
  assign o_ch1_block_done     = bdone[1];
endmodule : dmarh_top
`default_nettype wire

// >>> tb/dmarh_peer.sv
/* Requesting device model: raises its request while it has data.
   Assumes i_clear is the controller's registered clear pulse. */
`timescale 1ns/10ps
`default_nettype none
module dmarh_peer (
  input  wire logic i_clk,
  input  wire logic i_want,
  input  wire logic i_slow,
  input  wire logic i_clear,
  output var logic  o_req = 1'b0
);
  logic [3:0] clr_d = 4'h0;
  // A slow device lets go late, so the controller must wait for it
  always_ff @(posedge i_clk) begin
    clr_d <= {clr_d[2:0], i_clear};
    o_req <= (i_slow ? clr_d[3] : i_clear) ? 1'b0 : i_want;
  end
endmodule : dmarh_peer
`default_nettype wire

// >>> tb/dmarh_properties.sv
/* Checker for dmarh_top handshake outputs.
   Assumes it is bound to every dmarh_top instance. */
`timescale 1ns/10ps
`default_nettype none
module dmarh_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ch0_xfer_request,
  input wire logic i_ch1_xfer_request,
  input wire logic i_ch0_ext_type,
  input wire logic i_ch1_ext_type,
  input wire logic i_ch0_burst,
  input wire logic i_ch1_burst,
  input wire logic o_ch0_xfer_start,
  input wire logic o_ch1_xfer_start,
  input wire logic o_ch0_block_done,
  input wire logic o_ch0_request_clear,
  input wire logic o_ch1_request_clear,
  input wire logic o_ch0_last_xfer_flag,
  input wire logic o_ch1_last_xfer_flag
);
  logic pend0;
  logic pend1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Set by a steal clear, dropped once the device lets go
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) pend0 <= 1'b0;
    else if (o_ch0_request_clear && !i_ch0_burst) pend0 <= 1'b1;
    else if (!i_ch0_xfer_request) pend0 <= 1'b0;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) pend1 <= 1'b0;
    else if (o_ch1_request_clear && !i_ch1_burst) pend1 <= 1'b1;
    else if (!i_ch1_xfer_request) pend1 <= 1'b0;
  end
  a_ch0_ext_gate: assert property (
    !i_ch0_ext_type [*2] |=> !o_ch0_xfer_start) else $error("ch0 start, not ext");
  a_ch1_ext_gate: assert property (
    !i_ch1_ext_type [*2] |=> !o_ch1_xfer_start) else $error("ch1 start, not ext");
  a_ch0_steal_clr: assert property (
    o_ch0_xfer_start && !i_ch0_burst |-> o_ch0_request_clear) else $error("ch0 no clear");
  a_ch0_wait_drop: assert property (
    o_ch0_xfer_start && !i_ch0_burst |-> !pend0) else $error("ch0 start before drop");
  a_ch0_burst_clr: assert property (
    o_ch0_request_clear && i_ch0_burst |-> o_ch0_last_xfer_flag) else $error("ch0 early clear");
  a_ch0_last_start: assert property (
    o_ch0_last_xfer_flag |-> o_ch0_xfer_start && o_ch0_request_clear) else $error("ch0 last");
  a_ch1_steal_clr: assert property (
    o_ch1_xfer_start && !i_ch1_burst |-> o_ch1_request_clear) else $error("ch1 no clear");
  a_ch1_last_start: assert property (
    o_ch1_last_xfer_flag |-> o_ch1_xfer_start && o_ch1_request_clear) else $error("ch1 last");
  a_ch1_wait_drop: assert property (
    o_ch1_xfer_start && !i_ch1_burst |-> !pend1) else $error("ch1 start before drop");
  a_ch1_burst_clr: assert property (
    o_ch1_request_clear && i_ch1_burst |-> o_ch1_last_xfer_flag) else $error("ch1 early clear");
  // A steal start needs the pin high two edges before the take
  a_ch0_sync_lag: assert property (
    !i_ch0_xfer_request ##2 !i_ch0_burst |=> !o_ch0_xfer_start) else $error("ch0 start too soon");
  cover property (o_ch0_last_xfer_flag && i_ch0_burst);
  cover property (o_ch1_last_xfer_flag && i_ch1_burst);
  cover property (o_ch1_request_clear);
  cover property (o_ch0_block_done);
endmodule : dmarh_properties
bind dmarh_top dmarh_properties chk_u (.i_clk, .i_rst_n, .i_ch0_xfer_request, .i_ch0_ext_type,
  .i_ch1_xfer_request,
  .i_ch1_ext_type, .i_ch0_burst, .i_ch1_burst, .o_ch0_xfer_start, .o_ch1_xfer_start,
  .o_ch0_block_done, .o_ch0_request_clear, .o_ch1_request_clear, .o_ch0_last_xfer_flag,
  .o_ch1_last_xfer_flag);
`default_nettype wire

// >>> tb/tb_top.sv
/* Testbench for dmarh_top with device models and a done engine.
   Assumes the checker is bound from its own file. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic [1:0] want = 2'h0, req, en = 2'h0, ext = 2'h0, burst = 2'h0, st, clr, lst, bd;
  logic [1:0] d1 = 2'h0, done = 2'h0;
  logic [31:0] cntv = 32'h0;
  integer ns[2], nc[2], nl[2], nb[2];
  int n_mismatch = 0, n_checks = 0, lat = 0;
  always #4 clk = ~clk;
  // Transfer engine answers two cycles after each start
  always @(posedge clk) begin
    d1 <= st;
    done <= d1;
    for (int c = 0; c < 2; c++) begin
      ns[c] = rst_n ? ns[c] + st[c] : 0;
      nc[c] = rst_n ? nc[c] + clr[c] : 0;
      nl[c] = rst_n ? nl[c] + lst[c] : 0;
      nb[c] = rst_n ? nb[c] + bd[c] : 0;
    end
  end
  dmarh_peer pr0 (.i_clk(clk), .i_want(want[0]), .i_slow(slow), .i_clear(clr[0]), .o_req(req[0]));
  dmarh_peer pr1 (.i_clk(clk), .i_want(want[1]), .i_slow(slow), .i_clear(clr[1]), .o_req(req[1]));
  dmarh_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_ch0_xfer_request(req[0]),
    .i_ch1_xfer_request(req[1]), .i_ch0_enable(en[0]), .i_ch1_enable(en[1]),
    .i_ch0_ext_type(ext[0]), .i_ch1_ext_type(ext[1]), .i_ch0_burst(burst[0]),
    .i_ch1_burst(burst[1]), .i_ch0_xfer_count(cntv[15:0]), .i_ch1_xfer_count(cntv[31:16]),
    .i_ch0_xfer_done(done[0]), .i_ch1_xfer_done(done[1]), .o_ch0_xfer_start(st[0]),
    .o_ch1_xfer_start(st[1]), .o_ch0_request_clear(clr[0]), .o_ch1_request_clear(clr[1]),
    .o_ch0_last_xfer_flag(lst[0]), .o_ch1_last_xfer_flag(lst[1]),
    .o_ch0_block_done(bd[0]), .o_ch1_block_done(bd[1]));
  task automatic chk(input string nm, input integer e, input integer g);
    n_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  task automatic chk4(input int c, input int s, input int k, input int l, input int b);
    chk("starts", s, ns[c]);
    chk("clears", k, nc[c]);
    chk("last flags", l, nl[c]);
    chk("block done", b, nb[c]);
  endtask : chk4
  // Reset before each block so no stale count carries over
  task automatic run(input int c, input int n);
    int k;
    @(posedge clk);
    rst_n <= 1'b0;
    cntv[16*c +: 16] <= 16'(n);
    en <= 2'h3;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    want[c] <= 1'b1;
    for (k = 0; k < 300 && lst[c] !== 1'b1; k++) @(posedge clk);
    lat = k;
    want <= 2'h0;
    repeat (20) @(posedge clk);
  endtask : run
  task automatic t_steal;
    ext <= 2'h3;
    run(0, 3);
    chk4(0, 3, 3, 1, 1);
  endtask : t_steal
  task automatic t_burst;
    burst <= 2'h1;
    run(0, 4);
    chk4(0, 4, 1, 1, 1);
  endtask : t_burst
  // Count of one in burst: clear and last flag ride on the only start;
  // pin high one edge after release, two sync edges, take, then seen here
  task automatic t_ch1_burst;
    burst <= 2'h2;
    run(1, 1);
    chk4(1, 1, 1, 1, 1);
    chk("request latency", 5, lat);
  endtask : t_ch1_burst
  task automatic t_ch1_slow;
    burst <= 2'h0;
    slow <= 1'b1;
    run(1, 2);
    chk4(1, 2, 2, 1, 1);
  endtask : t_ch1_slow
  task automatic t_ignore;
    ext <= 2'h0;
    want[1] <= 1'b1;
    run(0, 2);
    chk4(0, 0, 0, 0, 0);
    chk4(1, 0, 0, 0, 0);
  endtask : t_ignore
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    t_steal();
    t_burst();
    t_ch1_burst();
    t_ch1_slow();
    t_ignore();
    test_done();
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
